// file: hw/i2s_tx_defs.vh
// register map, field positions, reset values and frame constants of the i2s transmitter
`ifndef I2S_TX_DEFS_VH
`define I2S_TX_DEFS_VH

// ==================================================================
// apb register map (byte addresses)
`define ADDR_W           12
`define REG_CTRL         12'h000
`define REG_CLKDIV       12'h004
`define REG_TXDATA       12'h008
`define REG_STATUS       12'h00C

// ==================================================================
// control register command bits (self clearing; bit 0 reads back the enable state)
`define CTRL_ENABLE      0
`define CTRL_DISABLE     1
`define CTRL_SOFT_RESET  2

// ==================================================================
// status register bits
`define STAT_READY       0
`define STAT_UNDERRUN    1
`define STAT_RUNNING     2
`define STAT_WORD_SEL    3

// ==================================================================
// clock divider register
`define DIV_W            12
`define DIV_RESET        12'h000

// ==================================================================
// frame layout: two 16-bit slots, left in the upper half of txdata
`define SLOT_BITS        16
`define SLOTS_PER_FRAME  2
`define FRAME_BITS       (`SLOT_BITS * `SLOTS_PER_FRAME)
`define POS_W            5
`define POS_FIRST        5'h00
`define WS_BIT           4
`define HOLD_RESET       32'h00000000
`define WS_IDLE          1'b1

`endif

// file: hw/i2s_master_transmitter.v
// i2s master transmitter: apb slave, clock divider, frame and serial shift logic
//
// Summary of operation
// - link is serial data with two channels, word select, continuous serial clock.
// - device drives clock, word select and data; slave uses that clock.
// - audio words are 16 bits only.
// - bit rate is 16 bits times 2 channels times sample rate.
// - serial clock is peripheral clock divided by twice the divider register value.
// - integer divider only, so rates deviate when ratio is not integral.
// - frame sync acts as word select, data pin as serial data.
// - transmit only; only the three transmit lines exist.
// - each frame holds a left then a right 16-bit slot.
// - divider wide enough for 8 kHz to 48 kHz at this clock.
// - word select holds each level for one 16-bit word.
// - outputs change on falling clock edge; left after ws fall, one-bit delay.
// - serial clock runs continuously while transmission is enabled and the divider is nonzero.
//
// Register access over APB and the register offsets were chosen for this implementation.

`timescale 1ns/1ps

`include "i2s_tx_defs.vh"

module i2s_master_transmitter (
  input  wire                pclk,
  input  wire                presetn,
  input  wire                psel,
  input  wire                penable,
  input  wire                pwrite,
  input  wire [`ADDR_W-1:0]  paddr,
  input  wire [31:0]         pwdata,
  output wire [31:0]         prdata,
  output wire                pready,
  output wire                pslverr,
  output wire                transmit_clock_pin,
  output wire                transmit_frame_sync,
  output wire                transmit_data_pin
);

  // ==================================================================
  // states
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_RUN  = 2'b10;

  // ==================================================================
  // address decode, shared by read and write paths
  function hit;
    input [`ADDR_W-1:0] addr;
    input [`ADDR_W-1:0] offset;
    begin
      hit = (addr == offset);
    end
  endfunction

  // ==================================================================
  // status word layout
  function [31:0] status_word;
    input ready;
    input underrun;
    input run;
    input word_sel;
    begin
      status_word                 = 32'h00000000;
      status_word[`STAT_READY]    = ready;
      status_word[`STAT_UNDERRUN] = underrun;
      status_word[`STAT_RUNNING]  = run;
      status_word[`STAT_WORD_SEL] = word_sel;
    end
  endfunction

  // ==================================================================
  // registers
  reg  [1:0]              state_ff;
  reg                     tx_en_ff;
  reg  [`DIV_W-1:0]       div_ff;
  reg  [`DIV_W-1:0]       cnt_ff;
  reg                     sck_ff;
  reg                     ws_ff;
  reg                     sd_ff;
  reg  [`FRAME_BITS-1:0]  shift_ff;
  reg  [`POS_W-1:0]       pos_ff;
  reg  [`FRAME_BITS-1:0]  hold_ff;
  reg                     hold_full_ff;
  reg                     underrun_ff;
  reg  [31:0]             prdata_ff;
  reg                     pready_ff;
  reg                     pslverr_ff;

  reg  [1:0]              nxt_state;
  reg                     nxt_tx_en;
  reg  [`DIV_W-1:0]       nxt_div;
  reg  [`DIV_W-1:0]       nxt_cnt;
  reg                     nxt_sck;
  reg                     nxt_ws;
  reg                     nxt_sd;
  reg  [`FRAME_BITS-1:0]  nxt_shift;
  reg  [`POS_W-1:0]       nxt_pos;
  reg  [`FRAME_BITS-1:0]  nxt_hold;
  reg                     nxt_hold_full;
  reg                     nxt_underrun;
  reg  [31:0]             nxt_prdata;
  reg                     nxt_pready;
  reg                     nxt_pslverr;

  wire                    setup_phase;
  wire                    wr_access;
  wire                    mapped;
  wire                    ctrl_wr;
  wire                    soft_reset;
  wire                    div_nz;
  wire                    tick;
  wire                    fall;
  wire                    load_frame;
  wire                    running;
  wire                    div_wr;
  wire                    data_wr;
  wire                    stat_wr;
  wire                    frame_take;
  wire                    underrun_set;

  // ==================================================================
  // apb strobes
  // pready is registered, so every access takes exactly one wait-free access cycle
  assign setup_phase = psel & ~penable;
  assign wr_access   = psel & penable & pready_ff & pwrite;
  assign mapped      = hit(paddr, `REG_CTRL) | hit(paddr, `REG_CLKDIV) |
                       hit(paddr, `REG_TXDATA) | hit(paddr, `REG_STATUS);
  assign ctrl_wr     = wr_access & hit(paddr, `REG_CTRL);
  assign soft_reset  = ctrl_wr & pwdata[`CTRL_SOFT_RESET];
  // write strobes, one per writable register
  assign div_wr      = wr_access & hit(paddr, `REG_CLKDIV);
  assign data_wr     = wr_access & hit(paddr, `REG_TXDATA);
  assign stat_wr     = wr_access & hit(paddr, `REG_STATUS);

  // ==================================================================
  // serial clock divider
  // a zero divider would give no clock at all, so it keeps the link idle
  assign div_nz     = (div_ff != `DIV_RESET);
  assign running    = (state_ff == ST_RUN);
  // >= so that shrinking the divider mid-count cannot strand the counter
  assign tick       = running & (cnt_ff >= div_ff - 1'b1);
  assign fall       = tick & sck_ff;
  assign load_frame = fall & (pos_ff == `POS_FIRST);
  // a frame is only taken while still enabled; an empty holder then underruns
  assign frame_take   = load_frame & tx_en_ff & div_nz;
  assign underrun_set = frame_take & ~hold_full_ff;

  // ==================================================================
  // next state
  always @* begin
    nxt_state     = state_ff;
    nxt_tx_en     = tx_en_ff;
    nxt_div       = div_ff;
    nxt_cnt       = cnt_ff;
    nxt_sck       = sck_ff;
    nxt_ws        = ws_ff;
    nxt_sd        = sd_ff;
    nxt_shift     = shift_ff;
    nxt_pos       = pos_ff;
    nxt_hold      = hold_ff;
    nxt_hold_full = hold_full_ff;
    nxt_underrun  = underrun_ff;

    // --------------------------------------------------------------
    // link engine
    case (state_ff)
      ST_IDLE: begin
        // idle: clock low, word select high, data zero
        nxt_cnt   = `DIV_RESET;
        nxt_sck   = 1'b0;
        nxt_ws    = `WS_IDLE;
        nxt_sd    = 1'b0;
        nxt_pos   = `POS_FIRST;
        nxt_shift = {`FRAME_BITS{1'b0}};
        if (tx_en_ff & div_nz) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (~tx_en_ff | ~div_nz) begin
          // stop at once, mid-frame; the partial frame is dropped
          nxt_state = ST_IDLE;
          nxt_sck   = 1'b0;
          nxt_ws    = `WS_IDLE;
          nxt_sd    = 1'b0;
        end else if (tick) begin
          nxt_cnt = `DIV_RESET;
          nxt_sck = ~sck_ff;
        end else begin
          nxt_cnt = cnt_ff + 1'b1;
        end
        if (fall & tx_en_ff & div_nz) begin
          // first bit after the ws fall is the previous right lsb
          nxt_sd  = shift_ff[`FRAME_BITS-1];
          nxt_ws  = pos_ff[`WS_BIT];
          nxt_pos = pos_ff + 1'b1;
          if (load_frame) begin
            // an empty holding register sends a silent frame
            nxt_shift = hold_full_ff ? hold_ff : {`FRAME_BITS{1'b0}};
          end else begin
            nxt_shift = {shift_ff[`FRAME_BITS-2:0], 1'b0};
          end
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase

    // --------------------------------------------------------------
    // holding register consumption
    if (frame_take) begin
      if (hold_full_ff) begin
        nxt_hold_full = 1'b0;
      end else begin
        nxt_underrun = 1'b1;
      end
    end

    // --------------------------------------------------------------
    // register writes
    if (ctrl_wr & pwdata[`CTRL_ENABLE]) begin
      nxt_tx_en = 1'b1;
    end
    // disable wins over enable when both are written
    if (ctrl_wr & pwdata[`CTRL_DISABLE]) begin
      nxt_tx_en = 1'b0;
    end
    if (div_wr) begin
      nxt_div = pwdata[`DIV_W-1:0];
    end
    if (data_wr) begin
      // a write while full overwrites the pending frame
      nxt_hold      = pwdata;
      nxt_hold_full = 1'b1;
    end
    // write one to clear; a new underrun in the same cycle wins
    if (stat_wr & pwdata[`STAT_UNDERRUN] & ~underrun_set) begin
      nxt_underrun = 1'b0;
    end

    // --------------------------------------------------------------
    // soft reset returns everything except the apb answer flip-flops to its reset value
    if (soft_reset) begin
      nxt_state     = ST_IDLE;
      nxt_tx_en     = 1'b0;
      nxt_div       = `DIV_RESET;
      nxt_cnt       = `DIV_RESET;
      nxt_sck       = 1'b0;
      nxt_ws        = `WS_IDLE;
      nxt_sd        = 1'b0;
      nxt_shift     = {`FRAME_BITS{1'b0}};
      nxt_pos       = `POS_FIRST;
      nxt_hold      = `HOLD_RESET;
      nxt_hold_full = 1'b0;
      nxt_underrun  = 1'b0;
    end
  end

  // ==================================================================
  // apb answer, prepared in the setup cycle
  always @* begin
    nxt_pready  = setup_phase;
    nxt_pslverr = setup_phase & ~mapped;
    nxt_prdata  = 32'h00000000;
    if (setup_phase & ~pwrite) begin
      if (hit(paddr, `REG_CTRL)) begin
        nxt_prdata[`CTRL_ENABLE] = tx_en_ff;
      end
      if (hit(paddr, `REG_CLKDIV)) begin
        nxt_prdata[`DIV_W-1:0] = div_ff;
      end
      if (hit(paddr, `REG_TXDATA)) begin
        nxt_prdata = hold_ff;
      end
      if (hit(paddr, `REG_STATUS)) begin
        nxt_prdata = status_word(~hold_full_ff, underrun_ff, running, ws_ff);
      end
    end
  end

  // ==================================================================
  // apb answer flip-flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff    <= 32'h00000000;
      pready_ff    <= 1'b0;
      pslverr_ff   <= 1'b0;
    end else begin
      prdata_ff    <= nxt_prdata;
      pready_ff    <= nxt_pready;
      pslverr_ff   <= nxt_pslverr;
    end
  end

  // ==================================================================
  // software visible register flip-flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_en_ff     <= 1'b0;
      div_ff       <= `DIV_RESET;
      hold_ff      <= `HOLD_RESET;
      hold_full_ff <= 1'b0;
      underrun_ff  <= 1'b0;
    end else begin
      tx_en_ff     <= nxt_tx_en;
      div_ff       <= nxt_div;
      hold_ff      <= nxt_hold;
      hold_full_ff <= nxt_hold_full;
      underrun_ff  <= nxt_underrun;
    end
  end

  // ==================================================================
  // link engine flip-flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff     <= ST_IDLE;
      cnt_ff       <= `DIV_RESET;
      sck_ff       <= 1'b0;
      ws_ff        <= `WS_IDLE;
      sd_ff        <= 1'b0;
      shift_ff     <= {`FRAME_BITS{1'b0}};
      pos_ff       <= `POS_FIRST;
    end else begin
      state_ff     <= nxt_state;
      cnt_ff       <= nxt_cnt;
      sck_ff       <= nxt_sck;
      ws_ff        <= nxt_ws;
      sd_ff        <= nxt_sd;
      shift_ff     <= nxt_shift;
      pos_ff       <= nxt_pos;
    end
  end

  // ==================================================================
  // outputs, all straight from flip-flops
  assign prdata              = prdata_ff;
  assign pready              = pready_ff;
  assign pslverr             = pslverr_ff;
  assign transmit_clock_pin  = sck_ff;
  assign transmit_frame_sync = ws_ff;
  assign transmit_data_pin   = sd_ff;

endmodule

// file: sim/i2s_tx_properties.sv
// port checker for the i2s master transmitter
`timescale 1ns/1ps
`include "i2s_tx_defs.vh"
module i2s_tx_properties (
  input wire               pclk,
  input wire               presetn,
  input wire               psel,
  input wire               penable,
  input wire               pwrite,
  input wire [`ADDR_W-1:0] paddr,
  input wire [31:0]        pwdata,
  input wire [31:0]        prdata,
  input wire               pready,
  input wire               pslverr,
  input wire               transmit_clock_pin,
  input wire               transmit_frame_sync,
  input wire               transmit_data_pin
);
  // ==========
  // helpers
  wire setup  = psel && !penable;
  wire mapped = paddr == `REG_CTRL || paddr == `REG_CLKDIV || paddr == `REG_TXDATA || paddr == `REG_STATUS;
  wire stop   = psel && penable && pready && pwrite && paddr == `REG_CTRL && (pwdata[1] || pwdata[2]);
  // sck low longer than the largest half period means the link is stopped
  reg [12:0] quiet_ff;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      quiet_ff <= 13'h0000;
    else if (transmit_clock_pin)
      quiet_ff <= 13'h0000;
    else if (!quiet_ff[12])
      quiet_ff <= quiet_ff + 13'h0001;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========
  // assertions
  property p_ready; setup |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("no pready after setup");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
  property p_err_with_ready; pslverr |-> pready; endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr without pready");
  property p_unmapped; setup && !mapped |=> pslverr && prdata == 32'h00000000; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_mapped; setup && mapped |=> !pslverr; endproperty
  a_mapped: assert property (p_mapped) else $error("mapped access refused");
  property p_on_fall; $changed(transmit_frame_sync) || $changed(transmit_data_pin) |-> !transmit_clock_pin; endproperty
  a_on_fall: assert property (p_on_fall) else $error("ws or data moved off a falling clock");
  property p_stop; stop |=> ##1 !transmit_clock_pin && transmit_frame_sync && !transmit_data_pin; endproperty
  a_stop: assert property (p_stop) else $error("link not idle after stop");
  property p_idle_hold; quiet_ff[12] |-> !transmit_data_pin && transmit_frame_sync; endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("stopped link not idle");
endmodule

// file: sim/i2s_dac_model.sv
// behavioural stereo dac on the far side of the link
`timescale 1ns/1ps
module i2s_dac_model (
  input  wire        sck,
  input  wire        ws,
  input  wire        sd,
  output reg  [31:0] frame_word,
  output reg  [7:0]  frame_cnt,
  output reg  [7:0]  left_len
);
  // ==========
  // receiver
  reg [30:0] sr;
  reg        ws_d;
  reg [7:0]  lo;
  // the optional return data line is left undriven; the block has no input for it
  initial begin
    sr = 31'h0;
    ws_d = 1'b1;
    lo = 8'h00;
    frame_word = 32'h0;
    frame_cnt = 8'h00;
    left_len = 8'h00;
  end
  // samples on the master clock only, it has no clock of its own
  always @(posedge sck) begin
    sr <= {sr[29:0], sd};
    ws_d <= ws;
    lo <= ws ? 8'h00 : lo + 8'h01;
    if (ws && !ws_d) begin
      left_len <= lo;
    end
    if (!ws && ws_d) begin
      frame_word <= {sr, sd};
      frame_cnt <= frame_cnt + 8'h01;
    end
  end
endmodule

// file: sim/tb.sv
// self-checking bench for the i2s master transmitter
`timescale 1ns/1ps
`include "i2s_tx_defs.vh"
module tb;
  reg               pclk, presetn, psel, penable, pwrite, err;
  reg [`ADDR_W-1:0] paddr;
  reg [31:0]        pwdata, rd;
  wire [31:0]       prdata, frame_word;
  wire              pready, pslverr, sck, ws, sd;
  wire [7:0]        frame_cnt, left_len;
  integer           n_mismatch, n_compared, n;
  i2s_master_transmitter uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .transmit_clock_pin(sck), .transmit_frame_sync(ws), .transmit_data_pin(sd));
  i2s_dac_model dac (.sck, .ws, .sd, .frame_word, .frame_cnt, .left_len);
  // ==========
  // shared tasks
  task check(input [95:0] name, input [31:0] seen, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("wrong value %0s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task final_report;
    begin
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task hang;
    begin
      n_mismatch = n_mismatch + 1;
      final_report;
    end
  endtask
  // no cycle count is assumed; the bound only cuts a hang short
  task apb(input w, input [`ADDR_W-1:0] a, input [31:0] d);
    integer i;
    begin
      i = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
        if (i == 20) hang;
        @(posedge pclk);
        i = i + 1;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task wait_cnt(input [7:0] target);
    begin
      n = 0;
      while (frame_cnt !== target) begin
        if (n == 3000) hang;
        @(posedge pclk);
        n = n + 1;
      end
    end
  endtask
  // ==========
  // scenarios
  task t_regs;
    begin
      apb(1'b0, `REG_STATUS, 32'h0);
      check("status", rd, 32'h00000009);
      apb(1'b1, `REG_CLKDIV, 32'h00000ABC);
      apb(1'b0, `REG_CLKDIV, 32'h0);
      check("clkdiv", rd, 32'h00000ABC);
      apb(1'b1, 12'h010, 32'hFFFFFFFF);
      check("unmapped wr", {31'h0, err}, 32'h00000001);
      apb(1'b0, 12'h010, 32'h0);
      check("unmapped rd", {rd[30:0], err}, 32'h00000001);
      apb(1'b1, `REG_CTRL, 32'h00000004);
      apb(1'b0, `REG_CLKDIV, 32'h0);
      check("clkdiv soft", rd, 32'h0);
    end
  endtask
  // divider 3 keeps frames short while an off-by-one still shows in the period
  task t_frame;
    begin
      apb(1'b1, `REG_CLKDIV, 32'h00000003);
      apb(1'b1, `REG_TXDATA, 32'hA5C31E69);
      apb(1'b1, `REG_CTRL, 32'h00000001);
      wait_cnt(8'h01);
      apb(1'b1, `REG_TXDATA, 32'h3C5A0F81);
      wait_cnt(8'h02);
      check("frame 1", frame_word, 32'hA5C31E69);
      check("left len", {24'h0, left_len}, 32'h00000010);
      wait_cnt(8'h03);
      check("frame clks", n, 32'h000000C0);
      check("frame 2", frame_word, 32'h3C5A0F81);
      wait_cnt(8'h04);
      check("empty frame", frame_word, 32'h0);
      apb(1'b0, `REG_STATUS, 32'h0);
      check("status run", rd & 32'h00000007, 32'h00000007);
    end
  endtask
  task t_stop;
    begin
      apb(1'b1, `REG_CTRL, 32'h00000002);
      repeat (8) @(posedge pclk);
      check("idle pins", {29'h0, sck, ws, sd}, 32'h00000002);
      apb(1'b0, `REG_STATUS, 32'h0);
      check("status stop", rd & 32'h00000004, 32'h0);
      repeat (4100) @(posedge pclk);
      check("idle long", {29'h0, sck, ws, sd}, 32'h00000002);
    end
  endtask
  // ==========
  // clock, reset and sequence
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    n_mismatch = 0;
    n_compared = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b1, `REG_CTRL, 32'h00000004);
    t_regs;
    t_frame;
    t_stop;
    final_report;
  end
endmodule
bind i2s_master_transmitter i2s_tx_properties u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .transmit_clock_pin, .transmit_frame_sync, .transmit_data_pin);
